//--- design/ioir_reporter.sv
// io event interrupt reporter with classic wishbone register slave
`timescale 1ns/100ps
`include "ioir_map.svh"
module ioir_reporter #(
  parameter int NUM_DIN  = 16,
  parameter int NUM_DOUT = 12
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic [NUM_DIN-1:0]     din_pin,
  input  wire ioir_pkg::ioir_chan_ev_t chan_ev,
  input  wire ioir_pkg::ioir_supply_t supply_pin,
  output logic                        process_irq,
  output logic                        diag_irq,
  output logic [15:0]                 irq_base_addr,
  output logic [31:0]                 irq_event_word,
  output logic [NUM_DOUT-1:0]         dout,
  output ioir_pkg::ioir_led_t         led
);
  import ioir_pkg::*;

  initial begin
    if (NUM_DIN != 16) $error("ioir_reporter: event word holds 16 inputs");
    if (NUM_DOUT != 12) $error("ioir_reporter: indicator set covers 12");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [31:0]         ctrl;
    logic [15:0]         base;
    logic [3:0]          diag_en;
    logic [NUM_DOUT-1:0] dout;
    logic [31:0]         pend;
    logic [31:0]         evword;
    logic                proc_busy;
    logic                diag_busy;
    logic                diag_lost;
    logic [NUM_DIN-1:0]  din_prev;
    logic [3:0]          sup_prev;
    logic                gate_prev;
    logic                ack;
    logic [31:0]         rdat;
  } ioir_st_t;

  ioir_st_t st_q;
  ioir_st_t st_d;

  logic [NUM_DIN-1:0] din_lvl;
  logic [3:0]         sup_lvl;
  logic [31:0]        new_ev;
  logic [3:0]         diag_cause;
  logic               proc_allowed;
  ioir_mode_t         mode;
  logic               sw_gate3;
  logic               gate_lvl;

  ioir_sync #(
    .WIDTH(NUM_DIN + 5)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   ({din_pin, supply_pin, chan_ev.hardware_gate_lvl3}),
    .level_out({din_lvl, sup_lvl, gate_lvl})
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [7:0] cnt_byte(input logic [1:0] lim,
                                          input logic [1:0] cmp);
    // low counter in bits 2/3, high counter in bits 6/7
    return {cmp[1], lim[1], 2'b00, cmp[0], lim[0], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event word assembly

  assign mode = ioir_mode_t'(st_q.ctrl[`IOIR_CTRL_MODE_LO +: 2]);
  assign proc_allowed = st_q.ctrl[`IOIR_CTRL_SEL_BIT];
  assign sw_gate3 = st_q.ctrl[`IOIR_CTRL_GATE_LO];

  always_comb begin
    logic [3:0] lim;
    logic [7:0] b11;
    b11 = '0;
    lim = chan_ev.overflow | chan_ev.underflow | chan_ev.end_value;
    new_ev = '0;
    // input edges in bytes 8 and 9
    new_ev[15:0] = din_lvl ^ st_q.din_prev;
    unique case (mode)
      IOIR_MODE_COUNTER: begin
        new_ev[23:16] = cnt_byte(lim[1:0], chan_ev.cmp_hit[1:0]);
        b11 = cnt_byte(lim[3:2], chan_ev.cmp_hit[3:2]);
        // gate 3 edges while software gate open
        b11[4] = sw_gate3 & gate_lvl & ~st_q.gate_prev;
        b11[5] = sw_gate3 & ~gate_lvl & st_q.gate_prev;
        new_ev[31:24] = b11;
      end
      IOIR_MODE_FREQ: begin
        new_ev[16] = chan_ev.meas_end[0];
        new_ev[20] = chan_ev.meas_end[1];
        new_ev[24] = chan_ev.meas_end[2];
        new_ev[28] = chan_ev.meas_end[3];
      end
      IOIR_MODE_INPUTS: b11 = '0;
      IOIR_MODE_OFF: begin
        new_ev = '0;
      end
    endcase
    if (mode != IOIR_MODE_COUNTER) b11 = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic causes

  always_comb begin
    diag_cause = '0;
    diag_cause[`IOIR_DIAG_LOST]    = st_q.diag_lost;
    diag_cause[`IOIR_DIAG_OUT_PWR] = ~sup_lvl[1];
    diag_cause[`IOIR_DIAG_IN_PWR]  = ~sup_lvl[2];
    diag_cause[`IOIR_DIAG_SHORT]   = sup_lvl[0];
    diag_cause = diag_cause & st_q.diag_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic wr;
    logic rd;
    logic ack_proc;
    logic ack_diag;
    logic [31:0] ev;
    logic [31:0] mrg_base;
    logic [31:0] mrg_dout;
    mrg_base = wb_merge({16'h0000, st_q.base}, wb_dat_i, wb_sel_i);
    mrg_dout = wb_merge({20'h00000, st_q.dout}, wb_dat_i, wb_sel_i);
    st_d = st_q;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ~st_q.ack;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_q.ack;
    ack_proc = 1'b0;
    ack_diag = 1'b0;
    ev = proc_allowed ? new_ev : 32'h0000_0000;
    st_d.din_prev  = din_lvl;
    st_d.sup_prev  = sup_lvl;
    st_d.gate_prev = gate_lvl;
    st_d.ack = wb_cyc_i & wb_stb_i & ~st_q.ack;
    if (wr) begin
      unique case (wb_adr_i)
        `IOIR_ADR_CTRL: st_d.ctrl = wb_merge(st_q.ctrl, wb_dat_i, wb_sel_i);
        `IOIR_ADR_BASE: begin
          st_d.base = mrg_base[15:0];
        end
        `IOIR_ADR_DIAG_EN: if (wb_sel_i[0]) st_d.diag_en = wb_dat_i[3:0];
        `IOIR_ADR_ACK: begin
          ack_proc = wb_sel_i[0] & wb_dat_i[`IOIR_ACK_PROC_BIT];
          ack_diag = wb_sel_i[0] & wb_dat_i[`IOIR_ACK_DIAG_BIT];
        end
        `IOIR_ADR_DOUT: begin
          st_d.dout = mrg_dout[NUM_DOUT-1:0];
        end
        default: st_d.ctrl = st_q.ctrl;
      endcase
    end
    if (ack_diag) begin
      st_d.diag_busy = 1'b0;
      st_d.diag_lost = 1'b0;
    end
    if (ack_proc) begin
      st_d.proc_busy = 1'b0;
      st_d.evword    = '0;
    end
    // repeat of an event in the delivered word while handled
    if (st_q.proc_busy & ~ack_proc & |(ev & st_q.evword)) begin
      st_d.diag_lost = 1'b1;
    end
    // new events pend; set wins over delivery
    st_d.pend = (ack_proc ? st_q.pend : st_q.pend) | ev;
    if (~st_d.proc_busy & |st_q.pend) begin
      st_d.evword    = st_q.pend;
      st_d.proc_busy = 1'b1;
      st_d.pend      = ev;
    end
    if (|diag_cause) st_d.diag_busy = 1'b1;
    st_d.rdat = '0;
    if (rd) begin
      unique case (wb_adr_i)
        `IOIR_ADR_CTRL:    st_d.rdat = st_q.ctrl;
        `IOIR_ADR_BASE:    st_d.rdat = {16'h0000, st_q.base};
        `IOIR_ADR_EVENT:   st_d.rdat = st_q.evword;
        `IOIR_ADR_STATUS: begin
          st_d.rdat = {24'h000000, diag_cause, sup_lvl[3:2],
                       st_q.diag_busy, st_q.proc_busy};
        end
        `IOIR_ADR_DIAG_EN: st_d.rdat = {28'h0000000, st_q.diag_en};
        `IOIR_ADR_DOUT:    st_d.rdat = {20'h00000, st_q.dout};
        default:           st_d.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q         <= '0;
      st_q.ctrl    <= `IOIR_RST_CTRL;
      st_q.base    <= `IOIR_RST_BASE;
      st_q.diag_en <= `IOIR_RST_DIAG_EN;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o       = st_q.ack;
  assign wb_dat_o       = st_q.rdat;
  assign process_irq    = st_q.proc_busy;
  assign diag_irq       = st_q.diag_busy;
  assign irq_base_addr  = st_q.base;
  assign irq_event_word = st_q.evword;
  assign dout           = st_q.dout;
  assign led.dout_led = st_q.dout;
  assign led.electronics_led   = sup_lvl[3];
  assign led.input_supply_led  = sup_lvl[2];
  assign led.output_supply_led = sup_lvl[1];
  assign led.output_fault_indicator = sup_lvl[0];
endmodule

//--- design/ioir_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module ioir_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } ioir_sync_st_t;

  ioir_sync_st_t st_q;
  ioir_sync_st_t st_d;

  initial begin
    if (WIDTH < 1) $error("ioir_sync: WIDTH must be at least 1");
  end

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a change is taken only once two settled stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule

//--- include/ioir_map.svh
// register offsets, field positions and reset values of the event reporter
`ifndef IOIR_MAP_SVH
`define IOIR_MAP_SVH
`define IOIR_ADR_CTRL     4'h0
`define IOIR_ADR_BASE     4'h1
`define IOIR_ADR_EVENT    4'h2
`define IOIR_ADR_STATUS   4'h3
`define IOIR_ADR_DIAG_EN  4'h4
`define IOIR_ADR_ACK      4'h5
`define IOIR_ADR_DOUT     4'h6
`define IOIR_CTRL_SEL_BIT 0
`define IOIR_CTRL_MODE_LO 1
`define IOIR_CTRL_GATE_LO 3
`define IOIR_ACK_PROC_BIT 0
`define IOIR_ACK_DIAG_BIT 1
`define IOIR_RST_CTRL     32'h0000_0000
`define IOIR_RST_BASE     16'h0000
`define IOIR_RST_DIAG_EN  4'h0
`define IOIR_DIAG_LOST    0
`define IOIR_DIAG_OUT_PWR 1
`define IOIR_DIAG_IN_PWR  2
`define IOIR_DIAG_SHORT   3
`endif

//--- include/ioir_pkg.sv
// types shared by the event reporter modules
package ioir_pkg;
  typedef enum logic [1:0] {
    IOIR_MODE_INPUTS,
    IOIR_MODE_COUNTER,
    IOIR_MODE_FREQ,
    IOIR_MODE_OFF
  } ioir_mode_t;

  typedef struct packed {
    logic [3:0] cmp_hit;
    logic [3:0] overflow;
    logic [3:0] underflow;
    logic [3:0] end_value;
    logic [3:0] meas_end;
    logic       hardware_gate_lvl3;
  } ioir_chan_ev_t;

  typedef struct packed {
    logic electronics_supply;
    logic input_power_supply;
    logic output_power_supply;
    logic output_short;
  } ioir_supply_t;

  typedef struct packed {
    logic [11:0] dout_led;
    logic        electronics_led;
    logic        input_supply_led;
    logic        output_supply_led;
    logic        output_fault_indicator;
  } ioir_led_t;
endpackage

//--- testbench/ioir_props.sv
// concurrent checks on the event reporter ports
`timescale 1ns/100ps
module ioir_props #(
  parameter int NUM_DIN  = 16,
  parameter int NUM_DOUT = 12
) (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [3:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire ioir_pkg::ioir_supply_t  supply_pin,
  input wire logic                    process_irq,
  input wire logic                    diag_irq,
  input wire logic [15:0]             irq_base_addr,
  input wire logic [31:0]             irq_event_word,
  input wire logic [NUM_DOUT-1:0]     dout,
  input wire ioir_pkg::ioir_led_t     led
);
  import ioir_pkg::*;
  logic [3:0]  ctl_q;
  logic [15:0] base_q;
  logic        wr;
  logic        clr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // shadow of the control and base registers, seen from the bus side
  // a write lands at the edge that takes it, the same edge that raises ack
  assign wr  = wb_cyc_i & wb_stb_i & !wb_ack_o & wb_we_i;
  assign clr = wr & (wb_adr_i == 4'h5) & wb_sel_i[0] & wb_dat_i[0];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q  <= 4'h0;
      base_q <= 16'h0;
    end else if (wr && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
      ctl_q <= wb_dat_i[3:0];
    end else if (wr && wb_adr_i == 4'h1 && wb_sel_i[1:0] == 2'h3) begin
      base_q <= wb_dat_i[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o) else $error("ack not one cycle after request");
  unmapped_zero_a: assert property ((wb_ack_o && !wb_we_i &&
    wb_adr_i > 4'h6) |-> wb_dat_o == 32'h0) else $error("unmapped read");
  irq_enable_a: assert property ($rose(process_irq) |-> ctl_q[0])
    else $error("process irq while selection off");
  base_addr_a: assert property ($rose(process_irq) |->
    irq_base_addr == base_q) else $error("base address mismatch");
  irq_hold_a: assert property (process_irq && !clr |=> process_irq)
    else $error("process irq dropped without ack");
  word_hold_a: assert property (process_irq && !clr |=>
    $stable(irq_event_word)) else $error("event word changed");
  input_rsvd_a: assert property (process_irq && ctl_q[2:1] == 2'h0 |->
    irq_event_word[31:16] == 16'h0) else $error("input mode reserved");
  count_rsvd_a: assert property (process_irq && ctl_q[2:1] == 2'h1 |->
    (irq_event_word[31:16] & 16'h0333) == 16'h0)
    else $error("counter mode reserved");
  freq_rsvd_a: assert property (process_irq && ctl_q[2:1] == 2'h2 |->
    (irq_event_word[31:16] & 16'heeee) == 16'h0)
    else $error("frequency mode reserved");
  dout_led_a: assert property ($stable(dout) |->
    led.dout_led == 12'(dout)) else $error("output led mismatch");
  supply_led_a: assert property ($stable(supply_pin)[*8] |->
    led.input_supply_led == supply_pin.input_power_supply &&
    led.output_supply_led == supply_pin.output_power_supply &&
    led.electronics_led == supply_pin.electronics_supply)
    else $error("supply led mismatch");
  fault_led_a: assert property ($stable(supply_pin)[*8] |->
    led.output_fault_indicator == supply_pin.output_short)
    else $error("fault led mismatch");
  cover property ($rose(process_irq));
  cover property ($rose(diag_irq));
  cover property (clr);
endmodule
bind ioir_reporter ioir_props #(.NUM_DIN(NUM_DIN), .NUM_DOUT(NUM_DOUT))
  ioir_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_pin(supply_pin),
  .process_irq(process_irq), .diag_irq(diag_irq),
  .irq_base_addr(irq_base_addr), .irq_event_word(irq_event_word),
  .dout(dout), .led(led));

//--- testbench/ioir_reporter_tb.sv
// self-checking bench of the event reporter
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ioir_reporter_tb;
  import ioir_pkg::*;
  logic core_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] wdat = 0, rdat, q, word;
  logic [15:0] din = 0, base;
  ioir_chan_ev_t chan_ev = '0;
  ioir_supply_t supply_pin = 4'b1110;
  logic pirq, dirq;
  logic [11:0] dout;
  ioir_led_t led;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  ioir_reporter ioir_reporter_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .din_pin(din), .chan_ev(chan_ev), .supply_pin(supply_pin),
    .process_irq(pirq), .diag_irq(dirq), .irq_base_addr(base),
    .irq_event_word(word), .dout(dout), .led(led));
  always #5 core_clk = ~core_clk;
  // a hang ends the run through the same report as a normal finish
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_sig(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic expect_word(input logic [31:0] e);
    wait_sig(pirq);
    `CHK("process_irq", 1'b1, pirq)
    `CHK("event_word", e, word)
    wb(1, 4'h5, 32'h1);
    @(posedge core_clk);
    `CHK("word_cleared", 32'h0, word)
  endtask
  task automatic pulse(input ioir_chan_ev_t v);
    @(posedge core_clk);
    chan_ev <= v;
    @(posedge core_clk);
    chan_ev <= '0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1, 4'h1, 32'h0000_1234);
    wb(0, 4'h1, 0);
    `CHK("base_reg", 16'h1234, q[15:0])
    wb(1, 4'hf, 32'hffff_ffff);
    wb(0, 4'hf, 0);
    `CHK("unmapped", 32'h0, q)
  endtask
  task automatic t_inputs();
    wb(1, 4'h0, 32'h1);
    @(posedge core_clk) din <= din ^ 16'h8001;
    expect_word(32'h0000_8001);
    `CHK("irq_base", 16'h1234, base)
    wb(1, 4'h0, 32'h0);
    @(posedge core_clk) din <= din ^ 16'h0002;
    repeat (20) @(posedge core_clk);
    `CHK("irq_gated", 1'b0, pirq)
  endtask
  task automatic t_counter();
    wb(1, 4'h0, 32'hb);
    pulse('{4'hf, 4'h9, 4'h2, 4'h4, 4'hf, 1'b0});
    expect_word(32'hcccc_0000);
    @(posedge core_clk) chan_ev.hardware_gate_lvl3 <= 1'b1;
    expect_word(32'h1000_0000);
    @(posedge core_clk) chan_ev.hardware_gate_lvl3 <= 1'b0;
    expect_word(32'h2000_0000);
  endtask
  task automatic t_freq();
    wb(1, 4'h0, 32'h5);
    pulse('{4'hf, 4'h0, 4'h0, 4'h0, 4'hf, 1'b0});
    expect_word(32'h1111_0000);
  endtask
  task automatic t_diag();
    wb(1, 4'h4, 32'h1);
    wb(1, 4'h0, 32'h1);
    @(posedge core_clk) din <= din ^ 16'h0001;
    wait_sig(pirq);
    @(posedge core_clk) din <= din ^ 16'h0001;
    wait_sig(dirq);
    `CHK("diag_lost", 1'b1, dirq)
    wb(1, 4'h5, 32'h3);
    repeat (10) @(posedge core_clk);
    wb(1, 4'h5, 32'h3);
  endtask
  task automatic t_leds();
    wb(1, 4'h6, 32'h0000_0a5c);
    repeat (3) @(posedge core_clk);
    `CHK("dout", 12'ha5c, dout)
    `CHK("dout_led", 12'ha5c, led.dout_led)
    wb(1, 4'h4, 32'h8);
    @(posedge core_clk) supply_pin <= 4'b1011;
    repeat (12) @(posedge core_clk);
    `CHK("supply_leds", 3'b101, {led.electronics_led,
      led.input_supply_led, led.output_supply_led})
    `CHK("fault_led", 1'b1, led.output_fault_indicator)
    `CHK("diag_short", 1'b1, dirq)
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_inputs();
    t_counter();
    t_freq();
    t_diag();
    t_leds();
    wrap_up();
  end
endmodule
